//--- adcc_regs.vh
// Register offsets, field positions and reset values of the converter control block.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one register per aligned word.
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH
// Offsets are register indexes; byte address is four times the index
`define ADCC_IDX_DIGITAL_INPUT_DISABLE 4'h1
`define ADCC_IDX_CONTROL_B 4'h3
`define ADCC_IDX_RESULT_LOW 4'h4
`define ADCC_IDX_RESULT_HIGH 4'h5
`define ADCC_IDX_CONTROL_A 4'h6
// Control A fields
`define ADCC_A_ENABLE 7
`define ADCC_A_START 6
`define ADCC_A_AUTO 5
`define ADCC_A_DONE 4
`define ADCC_A_IRQEN 3
// Control B fields
`define ADCC_B_BIPOLAR 7
`define ADCC_B_COMP_MUX 6
`define ADCC_B_LEFT 4
// Reset values
`define ADCC_RST_CONTROL_A 8'h00
`define ADCC_RST_CONTROL_B 8'h00
`define ADCC_RST_DIDR 8'h00
`define ADCC_RST_RESULT 10'h000
// Conversion length in converter clocks, normal and first after enable
`define ADCC_CONV_NORMAL 5'h0D
`define ADCC_CONV_FIRST 5'h19
`endif

//--- adcc_control_result_regs.v
// Control, trigger, prescaler and result registers of a 10-bit converter.
// Assumes an analog core that returns a sample on conv_sample_in and peripheral flags on aclk.
//
// Our own choice: the AXI4-Lite register port.
`include "adcc_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - With auto trigger on, each rising edge of selected source while enabled and idle starts a conversion.
// - Done flag sets when conversion ends and result registers are loaded.
// - Interrupt request only when flag, its enable and global enable are set.
// - Entering the matching interrupt vector clears the done flag.
// - Writing one to the done flag clears it; writing zero keeps it.
// - Converter clock is system clock divided 2,2,4,8,16,32,64,128 by selector.
// - Right adjust: low byte bits 7..0, high byte bits 9..8, rest zero.
// - Left adjust: high byte bits 9..2, low byte bits 1..0 at top.
// - After low byte read, result updates are blocked until high byte read.
// - Changing left adjust re-maps visible result immediately.
// - Unipolar results are 10-bit one-sided, saturated when negative input exceeds.
// - Bipolar select gives two's complement: nine magnitude bits plus sign.
// - Reserved bits 5 and 3 of control B read back what was written.
// - Trigger source field is ignored while auto trigger is off.
// - Switching selection from clear to set flag is a rising edge.
// - Selecting free-running code zero never itself makes a trigger.
// - Codes: free run, comparator, ext int 0, T0 cmpA, T0 ovf, T1 cmpB, T1 ovf, T1 capt.
// - Disable bit turns off the pin input buffer and forces its port bit zero.
// - Start bit reads one during conversion, zero after; writing zero does nothing.
// - Clearing converter enable switches it off and aborts a running conversion.
module adcc_control_result_regs (
  input wire aclk,
  input wire aresetn,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire global_irq_enable,
  input wire irq_vector_ack,
  input wire comparator_out,
  input wire ext_int0_flag,
  input wire t0_compare_a_flag,
  input wire t0_overflow_flag,
  input wire t1_compare_b_flag,
  input wire t1_overflow_flag,
  input wire t1_capture_flag,
  input wire [9:0] conv_sample_in,
  input wire conv_negative_over,
  output wire converter_on,
  output wire conv_clk_en,
  output reg conv_start,
  output wire bipolar_mode,
  output wire comparator_mux_enable,
  input wire [7:0] pin_level_in,
  output wire [7:0] pin_buffer_disable_bits,
  output reg [7:0] port_input_bits,
  output wire conv_irq
);

localparam ST_IDLE = 1'b0;
localparam ST_CONV = 1'b1;

reg [7:0] ctrl_a_reg;
reg [7:0] ctrl_b_reg;
reg [7:0] didr_reg;
reg [9:0] result_reg;
reg done_reg;
reg lock_reg;
reg state_reg;
reg first_reg;
reg [4:0] conv_cnt_reg;
reg [6:0] presc_reg;
reg trig_prev_reg;
reg conv_end_reg;
reg [7:0] pin_meta_reg;
reg [7:0] pin_sync_reg;
reg aw_full_reg;
reg [4:0] aw_addr_reg;
reg w_full_reg;
reg [7:0] w_data_reg;
reg w_lane_reg;

////////////////////////////////////////////////////////////////////////////////
// Helpers

function [6:0] div_mask;
  input [2:0] sel;
  begin
    case (sel)
      3'h0, 3'h1: div_mask = 7'h01;
      3'h2: div_mask = 7'h03;
      3'h3: div_mask = 7'h07;
      3'h4: div_mask = 7'h0F;
      3'h5: div_mask = 7'h1F;
      3'h6: div_mask = 7'h3F;
      default: div_mask = 7'h7F;
    endcase
  end
endfunction

function [7:0] result_byte;
  input [9:0] res;
  input left;
  input high;
  begin
    if (left) begin
      result_byte = high ? res[9:2] : {res[1:0], 6'h00};
    end else begin
      result_byte = high ? {6'h00, res[9:8]} : res[7:0];
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Prescaler: enable pulse at the end of each divided period

wire [6:0] mask = div_mask(ctrl_a_reg[2:0]);
assign conv_clk_en = ctrl_a_reg[`ADCC_A_ENABLE] && ((presc_reg & mask) == mask);

always @(posedge aclk) begin
  if (!aresetn || !ctrl_a_reg[`ADCC_A_ENABLE]) begin
    presc_reg <= 7'h00;
  end else begin
    presc_reg <= presc_reg + 7'h01;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Trigger selection and edge detection

reg trig_sel;
always @* begin
  case (ctrl_b_reg[2:0])
    3'h0: trig_sel = done_reg;
    3'h1: trig_sel = comparator_out;
    3'h2: trig_sel = ext_int0_flag;
    3'h3: trig_sel = t0_compare_a_flag;
    3'h4: trig_sel = t0_overflow_flag;
    3'h5: trig_sel = t1_compare_b_flag;
    3'h6: trig_sel = t1_overflow_flag;
    default: trig_sel = t1_capture_flag;
  endcase
end

// Free run restarts on each completion only, so selecting it with the flag set starts nothing
wire free_run = (ctrl_b_reg[2:0] == 3'h0);
wire trig_edge = trig_sel && !trig_prev_reg;
wire auto_start = ctrl_a_reg[`ADCC_A_AUTO] && (free_run ? conv_end_reg : trig_edge);

always @(posedge aclk) begin
  if (!aresetn) begin
    trig_prev_reg <= 1'b0;
  end else begin
    trig_prev_reg <= trig_sel;
  end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave

wire wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
wire rd_fire = s_axi_arvalid && !s_axi_rvalid;
assign s_axi_awready = !aw_full_reg;
assign s_axi_wready = !w_full_reg;
assign s_axi_arready = !s_axi_rvalid;

always @(posedge aclk) begin
  if (!aresetn) begin
    aw_full_reg <= 1'b0;
    aw_addr_reg <= 5'h00;
    w_full_reg <= 1'b0;
    w_data_reg <= 8'h00;
    w_lane_reg <= 1'b0;
  end else begin
    if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_reg <= 1'b0;
    end
    if (s_axi_wvalid && !w_full_reg) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata[7:0];
      w_lane_reg <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_full_reg <= 1'b0;
    end
  end
end

// Byte address is four times the register index; low address bits are ignored
wire [3:0] widx = {1'b0, aw_addr_reg[4:2]};
wire [3:0] ridx = {1'b0, s_axi_araddr[4:2]};

wire wr_ok = w_lane_reg;
wire wr_didr = wr_fire && wr_ok && (widx == `ADCC_IDX_DIGITAL_INPUT_DISABLE);
wire wr_b = wr_fire && wr_ok && (widx == `ADCC_IDX_CONTROL_B);
wire wr_ctrl_a = wr_fire && wr_ok && (widx == `ADCC_IDX_CONTROL_A);
wire rd_low = rd_fire && (ridx == `ADCC_IDX_RESULT_LOW);
wire rd_high = rd_fire && (ridx == `ADCC_IDX_RESULT_HIGH);

////////////////////////////////////////////////////////////////////////////////
// Conversion sequencing

wire sw_start = wr_ctrl_a && w_data_reg[`ADCC_A_START] && w_data_reg[`ADCC_A_ENABLE];
wire enable_next = wr_ctrl_a ? w_data_reg[`ADCC_A_ENABLE] : ctrl_a_reg[`ADCC_A_ENABLE];
wire conv_end = (state_reg == ST_CONV) && conv_clk_en && (conv_cnt_reg == 5'h01);
wire done_set_now = conv_end && !lock_reg;
// Enable written together with start must still launch the first conversion
wire begin_conv = (state_reg == ST_IDLE) && enable_next && (sw_start || auto_start);

always @(posedge aclk) begin
  if (!aresetn) begin
    state_reg <= ST_IDLE;
    conv_cnt_reg <= 5'h00;
    first_reg <= 1'b1;
    conv_start <= 1'b0;
    conv_end_reg <= 1'b0;
  end else begin
    conv_start <= begin_conv;
    conv_end_reg <= conv_end;
    if (!enable_next) begin
      state_reg <= ST_IDLE;
      first_reg <= 1'b1;
      conv_cnt_reg <= 5'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (begin_conv) begin
            state_reg <= ST_CONV;
            conv_cnt_reg <= first_reg ? `ADCC_CONV_FIRST : `ADCC_CONV_NORMAL;
            first_reg <= 1'b0;
          end
        end
        default: begin
          if (conv_clk_en) begin
            conv_cnt_reg <= conv_cnt_reg - 5'h01;
            if (conv_cnt_reg == 5'h01) begin
              state_reg <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Result, lock and flag

// Unipolar saturates to full scale; bipolar keeps the core's two's complement word
wire [9:0] sample = (!ctrl_b_reg[`ADCC_B_BIPOLAR] && conv_negative_over) ? 10'h3FF : conv_sample_in;

always @(posedge aclk) begin
  if (!aresetn) begin
    result_reg <= `ADCC_RST_RESULT;
    lock_reg <= 1'b0;
    done_reg <= 1'b0;
  end else begin
    if (done_set_now) begin
      result_reg <= sample;
    end
    if (rd_low) begin
      lock_reg <= 1'b1;
    end else if (rd_high) begin
      lock_reg <= 1'b0;
    end
    if (done_set_now) begin
      done_reg <= 1'b1;
    end else if (irq_vector_ack) begin
      done_reg <= 1'b0;
    end else if (wr_ctrl_a && w_data_reg[`ADCC_A_DONE]) begin
      done_reg <= 1'b0;
    end
  end
end

assign conv_irq = done_reg && ctrl_a_reg[`ADCC_A_IRQEN] && global_irq_enable;

////////////////////////////////////////////////////////////////////////////////
// Control registers

always @(posedge aclk) begin
  if (!aresetn) begin
    ctrl_a_reg <= `ADCC_RST_CONTROL_A;
    ctrl_b_reg <= `ADCC_RST_CONTROL_B;
    didr_reg <= `ADCC_RST_DIDR;
  end else begin
    if (wr_ctrl_a) begin
      ctrl_a_reg <= {w_data_reg[7], 1'b0, w_data_reg[5], 1'b0, w_data_reg[3:0]};
    end
    if (wr_b) begin
      ctrl_b_reg <= w_data_reg;
    end
    if (wr_didr) begin
      didr_reg <= w_data_reg;
    end
  end
end

assign converter_on = ctrl_a_reg[`ADCC_A_ENABLE];
assign bipolar_mode = ctrl_b_reg[`ADCC_B_BIPOLAR];
assign comparator_mux_enable = ctrl_b_reg[`ADCC_B_COMP_MUX];
assign pin_buffer_disable_bits = didr_reg;

always @(posedge aclk) begin
  if (!aresetn) begin
    pin_meta_reg <= 8'h00;
    pin_sync_reg <= 8'h00;
    port_input_bits <= 8'h00;
  end else begin
    pin_meta_reg <= pin_level_in;
    pin_sync_reg <= pin_meta_reg;
    port_input_bits <= pin_sync_reg & ~didr_reg;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Responses

wire [7:0] ctrl_a_view = {ctrl_a_reg[7], (state_reg == ST_CONV), ctrl_a_reg[5], done_reg, ctrl_a_reg[3:0]};
reg [7:0] rd_byte;
reg rd_map;
always @* begin
  rd_map = 1'b1;
  if (ridx == `ADCC_IDX_CONTROL_A) begin
    rd_byte = ctrl_a_view;
  end else if (ridx == `ADCC_IDX_RESULT_LOW) begin
    rd_byte = result_byte(result_reg, ctrl_b_reg[`ADCC_B_LEFT], 1'b0);
  end else if (ridx == `ADCC_IDX_RESULT_HIGH) begin
    rd_byte = result_byte(result_reg, ctrl_b_reg[`ADCC_B_LEFT], 1'b1);
  end else if (ridx == `ADCC_IDX_DIGITAL_INPUT_DISABLE) begin
    rd_byte = didr_reg;
  end else if (ridx == `ADCC_IDX_CONTROL_B) begin
    rd_byte = ctrl_b_reg;
  end else begin
    rd_byte = 8'h00;
    rd_map = 1'b0;
  end
end

always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= 2'h0;
    s_axi_rvalid <= 1'b0;
    s_axi_rresp <= 2'h0;
    s_axi_rdata <= 32'h00000000;
  end else begin
    if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_ctrl_a || wr_b || wr_didr || !wr_ok) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
    if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rd_map ? 2'h0 : 2'h2;
      s_axi_rdata <= {24'h000000, rd_byte};
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
end

endmodule // adcc_control_result_regs

//--- adcc_monitor.sv
// Port checker for the converter control block.
// Assumes binding onto adcc_control_result_regs, one clock aclk.
module adcc_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic global_irq_enable,
  input wire logic converter_on,
  input wire logic conv_clk_en,
  input wire logic conv_start,
  input wire logic [7:0] pin_buffer_disable_bits,
  input wire logic [7:0] port_input_bits,
  input wire logic conv_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  chk_irq_global: assert property (conv_irq |-> global_irq_enable)
    else $error("irq raised without global enable");
  chk_start_on: assert property (conv_start |-> converter_on)
    else $error("start while converter off");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  chk_clk_off: assert property (!converter_on |-> !conv_clk_en)
    else $error("converter clock runs while off");
  chk_div_min: assert property (conv_clk_en |=> !conv_clk_en)
    else $error("converter clock divide below two");
  // Mask may share the 3 cycle pin latency
  chk_pin_mask: assert property (pin_buffer_disable_bits == $past(pin_buffer_disable_bits, 3)
    |-> (port_input_bits & pin_buffer_disable_bits) == 8'h00)
    else $error("disabled pin reads one");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while read pending");
  chk_r_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
endmodule // adcc_monitor

bind adcc_control_result_regs adcc_monitor adcc_monitor_inst (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .global_irq_enable, .converter_on,
  .conv_clk_en, .conv_start, .pin_buffer_disable_bits, .port_input_bits, .conv_irq);

//--- adcc_core_model.sv
// Behavioural analog core: new sample per start.
// Assumes start pulses on aclk from the control block.
module adcc_core_model (
  input wire logic aclk,
  input wire logic conv_start,
  input wire logic neg_req,
  output logic [9:0] conv_sample_in,
  output logic conv_negative_over
);
  timeunit 1ns;
  timeprecision 1ps;
  initial conv_sample_in = 10'h155;
  // Inverting keeps a stale sample from passing as fresh
  always @(posedge aclk) if (conv_start) conv_sample_in <= ~conv_sample_in;
  assign conv_negative_over = neg_req;
endmodule // adcc_core_model

//--- adcc_control_result_regs_tb_top.sv
// Self-checking bench for the converter control block.
// Assumes AXI4-Lite map 0x04 input disable, 0x0C control B, 0x10/0x14 result, 0x18 control A.
module adcc_control_result_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] ADDR_A = 5'h18, ADDR_D = 5'h04, ADDR_B = 5'h0C, ADDR_L = 5'h10, ADDR_H = 5'h14;
  logic aclk = 0, aresetn = 0, neg_req = 0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic global_irq_enable = 1, irq_vector_ack = 0, comparator_out = 0, ext_int0_flag = 0;
  logic t0_compare_a_flag = 0, t0_overflow_flag = 0, t1_compare_b_flag = 0, t1_overflow_flag = 0;
  logic t1_capture_flag = 0, conv_negative_over, converter_on, conv_clk_en, conv_start;
  logic bipolar_mode, comparator_mux_enable, conv_irq;
  logic [9:0] conv_sample_in;
  logic [7:0] pin_level_in = 8'hFF, pin_buffer_disable_bits, port_input_bits, rdv;
  int fails = 0, comparisons = 0;
  always #5 aclk = ~aclk;
  adcc_control_result_regs adcc_control_result_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .global_irq_enable, .irq_vector_ack, .comparator_out, .ext_int0_flag, .t0_compare_a_flag,
    .t0_overflow_flag, .t1_compare_b_flag, .t1_overflow_flag, .t1_capture_flag, .conv_sample_in,
    .conv_negative_over, .converter_on, .conv_clk_en, .conv_start, .bipolar_mode, .comparator_mux_enable,
    .pin_level_in, .pin_buffer_disable_bits, .port_input_bits, .conv_irq);
  adcc_core_model adcc_core_model_inst (.aclk, .conv_start, .neg_req, .conv_sample_in, .conv_negative_over);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    if (n == 40) fails++;
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [4:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    if (n == 40) fails++;
    rdv = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 1500; n++) begin
      rd(ADDR_A);
      if (!rdv[6]) break;
    end
    if (n == 1500) fails++;
  endtask
  task automatic set_flag(input int k, input logic v);
    case (k)
      1: comparator_out <= v;
      2: ext_int0_flag <= v;
      3: t0_compare_a_flag <= v;
      4: t0_overflow_flag <= v;
      5: t1_compare_b_flag <= v;
      6: t1_overflow_flag <= v;
      default: t1_capture_flag <= v;
    endcase
  endtask
  // One-cycle flag pulse, then watch for a start
  task automatic pulse(input int k, input logic e);
    logic s;
    int i;
    @(posedge aclk);
    set_flag(k, 1);
    @(posedge aclk);
    set_flag(k, 0);
    s = 0;
    for (i = 0; i < 8; i++) begin
      @(posedge aclk);
      s = s | conv_start;
    end
    cmp("trigger start", e, s);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(ADDR_A); cmp("ctrl_a reset", 8'h00, rdv);
    rd(ADDR_B); cmp("ctrl_b reset", 8'h00, rdv);
    rd(ADDR_D); cmp("disable reset", 8'h00, rdv);
    rd(5'h08); cmp("unmapped read", 2'b10, resp);
    wr(5'h08, 8'hFF); cmp("unmapped write", 2'b10, resp);
    wr(ADDR_B, 8'hA8); rd(ADDR_B); cmp("ctrl_b readback", 8'hA8, rdv);
    cmp("bipolar", 1, bipolar_mode);
    wr(ADDR_B, 8'h40); cmp("comparator mux", 1, comparator_mux_enable);
    wr(ADDR_D, 8'h0F);
    repeat (4) @(posedge aclk);
    cmp("buffer disable", 8'h0F, pin_buffer_disable_bits);
    cmp("port bits", 8'hF0, port_input_bits);
    wr(ADDR_D, 8'h00);
    wr(ADDR_B, 8'h00);
  endtask
  task automatic t_done;
    wr(ADDR_A, 8'hC8); rd(ADDR_A); cmp("busy", 1, rdv[6]);
    wait_idle; rd(ADDR_A); cmp("done set", 8'h98, rdv);
    cmp("irq", 1, conv_irq);
    @(posedge aclk);
    global_irq_enable <= 0;
    @(posedge aclk);
    cmp("irq masked", 0, conv_irq);
    global_irq_enable <= 1;
    wr(ADDR_A, 8'h88); rd(ADDR_A); cmp("zero keeps", 8'h98, rdv);
    wr(ADDR_A, 8'h98); rd(ADDR_A); cmp("one clears", 8'h88, rdv);
    cmp("irq cleared", 0, conv_irq);
    wr(ADDR_A, 8'hC8); wait_idle;
    @(posedge aclk);
    irq_vector_ack <= 1;
    @(posedge aclk);
    irq_vector_ack <= 0;
    rd(ADDR_A); cmp("vector clears", 8'h88, rdv);
    wr(ADDR_A, 8'h00);
  endtask
  task automatic t_result;
    logic [9:0] s;
    wr(ADDR_A, 8'hC0); wait_idle;
    s = conv_sample_in;
    rd(ADDR_L); cmp("right low", s[7:0], rdv);
    rd(ADDR_H); cmp("right high", {6'h00, s[9:8]}, rdv);
    wr(ADDR_B, 8'h10); rd(ADDR_H); cmp("left high", s[9:2], rdv);
    rd(ADDR_L); cmp("left low", {s[1:0], 6'h00}, rdv);
    wr(ADDR_A, 8'hC0); wait_idle;
    rd(ADDR_H); cmp("locked high", s[9:2], rdv);
    neg_req <= 1;
    wr(ADDR_A, 8'hC0); wait_idle;
    rd(ADDR_H); cmp("saturated", 8'hFF, rdv);
    wr(ADDR_B, 8'h90); wr(ADDR_A, 8'hC0); wait_idle;
    rd(ADDR_H); cmp("bipolar result", conv_sample_in[9:2], rdv);
    neg_req <= 0;
    wr(ADDR_B, 8'h00);
    wr(ADDR_A, 8'h10);
  endtask
  task automatic t_presc;
    int c, g, k;
    for (c = 0; c < 8; c++) begin
      wr(ADDR_A, 8'hC0 | 8'(c));
      k = 0;
      do begin @(posedge aclk); k++; end while (!conv_clk_en && k < 300);
      g = 0;
      do begin @(posedge aclk); g++; end while (!conv_clk_en && g < 300);
      cmp("divider", (c < 2) ? 2 : (1 << c), g);
      wait_idle;
      wr(ADDR_A, 8'h10);
    end
  endtask
  task automatic t_trig;
    int k;
    wr(ADDR_A, 8'h80);
    for (k = 1; k < 8; k++) begin
      wr(ADDR_B, 8'(k));
      pulse(k, 0);
      wr(ADDR_A, 8'hA0);
      pulse(k, 1);
      wait_idle;
      wr(ADDR_A, 8'h90);
    end
    wr(ADDR_B, 8'h01);
    wr(ADDR_A, 8'hA0);
    ext_int0_flag <= 1;
    // Held flag on an unselected source, then switch onto it
    wr(ADDR_B, 8'h02); rd(ADDR_A); cmp("switch start", 1, rdv[6]);
    wait_idle;
    // Pass through a cleared source first so only the free-run guard can hold the start back
    wr(ADDR_B, 8'h01);
    wr(ADDR_B, 8'h00); rd(ADDR_A); cmp("free run no trigger", 8'hB0, rdv);
    ext_int0_flag <= 0;
    wr(ADDR_A, 8'hF0);
    k = 0;
    repeat (200) begin
      @(posedge aclk);
      k += conv_start;
    end
    cmp("free run restarts", 1, k > 2);
    wr(ADDR_A, 8'h10);
  endtask
  task automatic t_abort;
    wr(ADDR_A, 8'hC6);
    repeat (20) @(posedge aclk);
    wr(ADDR_A, 8'h00); rd(ADDR_A); cmp("abort", 8'h00, rdv);
    cmp("converter off", 0, converter_on);
  endtask
  task automatic summarize;
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    t_regs;
    t_done;
    t_result;
    t_presc;
    t_trig;
    t_abort;
    summarize;
  end
  initial begin
    #500us;
    fails++;
    summarize;
  end
endmodule // adcc_control_result_regs_tb_top
